// [include/mrd_pkg.sv]
package mrd_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int DEB_TIME_US = 1000;
  localparam int DEB_CYCLES = DEB_TIME_US * CLK_MHZ;
  localparam int REJECT_TIME_MS = 2000;
  localparam int REJECT_CYCLES = REJECT_TIME_MS * 1000 * CLK_MHZ;
  localparam int RAMP_STEP_US = 10;
  localparam int RAMP_CYCLES = RAMP_STEP_US * CLK_MHZ;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INMAP = 8'h08;
  localparam logic [7:0] ADDR_OUTMAP = 8'h0c;
  localparam logic [7:0] ADDR_SPEED0 = 8'h10;
  localparam logic [7:0] ADDR_LIMIT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_EDIT = 8'h28;
  localparam logic [7:0] ADDR_CMD = 8'h2c;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int SPW = 13;
  localparam int CTRL_EXT_LSB = 0;
  localparam int CTRL_LOCK_BIT = 2;
  localparam int CTRL_DISP_LSB = 4;
  localparam int LIMIT_LOWER_LSB = 16;
  localparam int CMD_INIT_DATA_BIT = 0;
  localparam int CMD_INIT_PARAM_BIT = 1;
  localparam int STAT_DIR_BIT = 16;
  localparam int STAT_REJECT_BIT = 17;
  localparam int STAT_STATE_LSB = 18;
  localparam int EDIT_BLINK_BIT = 16;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [1:0] EXT_RST = 2'h0;
  localparam logic [14:0] INMAP_RST = 15'h4688;
  localparam logic [3:0] OUTMAP_RST = 4'h4;
  localparam logic [SPW-1:0] UPPER_RST = 13'hfa0;
  localparam logic [SPW-1:0] LOWER_RST = 13'h032;
  localparam logic [SPW-1:0] SPEED_RST = 13'h032;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] EXT_PANEL = 2'h0;
  localparam logic [1:0] EXT_ON = 2'h1;
  localparam logic [1:0] EXT_LOCKED = 2'h2;
  localparam logic [2:0] DISP_SPEED = 3'h0;
  localparam logic [2:0] DISP_ALARM = 3'h1;
  localparam logic [2:0] DISP_WARN = 3'h2;
  localparam logic [2:0] DISP_DATA = 3'h4;
  localparam logic [2:0] FN_FWD = 3'h0;
  localparam logic [2:0] FN_REV = 3'h1;
  localparam logic [2:0] FN_SEL0 = 3'h2;
  localparam logic [2:0] FN_SEL1 = 3'h3;
  localparam logic [1:0] OFN_RUN = 2'h0;
  localparam logic [1:0] OFN_REJECT = 2'h1;
  localparam logic [1:0] OFN_REVDIR = 2'h2;
  localparam int NSW = 10;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RUN = 5'b00010,
    ST_DECEL = 5'b00100,
    ST_TURN = 5'b01000,
    ST_HALT = 5'b10000
  } mrd_state_t;
endpackage : mrd_pkg

// [include/mrd_sw_if.sv]
`timescale 1ns/1ps
interface mrd_sw_if;
  logic [mrd_pkg::NSW-1:0] raw;
  logic [mrd_pkg::NSW-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : mrd_sw_if

// [src/mrd_debounce.sv]
`timescale 1ns/1ps
module mrd_debounce
  import mrd_pkg::*;
#(
  parameter int DEB_CYC = DEB_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // switch lines
  mrd_sw_if.filt sw
);
  logic [NSW-1:0] s1_q, s2_q, clean_q, clean_d;
  logic [16:0] cnt_q [NSW];
  logic [16:0] cnt_d [NSW];

  // ----------------------------------------
  // two-stage sync then stable-time filter
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < NSW; i++) begin
      cnt_d[i] = 17'h0;
      clean_d[i] = clean_q[i];
      if (s2_q[i] != clean_q[i]) begin
        cnt_d[i] = cnt_q[i] + 17'h1;
        if (cnt_q[i] >= 17'(DEB_CYC - 1)) begin
          clean_d[i] = s2_q[i];
          cnt_d[i] = 17'h0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      clean_q <= '0;
      for (int i = 0; i < NSW; i++) cnt_q[i] <= 17'h0;
    end else begin
      s1_q <= sw.raw;
      s2_q <= s1_q;
      clean_q <= clean_d;
      for (int i = 0; i < NSW; i++) cnt_q[i] <= cnt_d[i];
    end
  end

  assign sw.clean = clean_q;
endmodule : mrd_debounce

// [src/mrd_motor_ctrl.sv]
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - mode off: only front run switch starts and stops; external inputs ignored
// - mode on: external run input with run switch at run rotates motor
// - mode on: run switch at standby gives deceleration stop despite inputs
// - mode on: setting dial changes the commanded speed
// - mode on: direction switch change reverses rotation
// - locked mode: run and direction switches ignored, rejection code shown
// - locked mode: dial on speed, alarm, warning view gives rejection code
// - locked mode: data, parameter and io monitor views stay settable
// - locked mode: rejection shown as long as run switch at run
// - locked mode: direction switch or dial shows rejection for two seconds
// - either forward or reverse run input asserted rotates the motor
// - releasing the run input ramps the motor down to stop
// - both run inputs asserted stop the motor instantly
// - rotation direction follows the direction switch position
// - direction change while running: decelerate, then restart other way
// - locked mode: direction switch ignored, forward direction used
// - external inputs select one of four stored speeds
// - commanded speed confined between programmable lower and upper limits
// - lock setting makes setting dial ineffective
// - function of five inputs and two outputs reassignable
// - edited value blinks, commits only when display returns to steady
// - separate commands restore operating data and parameters to defaults
module mrd_motor_ctrl
  import mrd_pkg::*;
#(
  parameter int DEB_CYC = DEB_CYCLES,
  parameter int REJ_CYC = REJECT_CYCLES
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external signal inputs and outputs
  input wire logic [4:0] ext_in,
  output logic [1:0] ext_out,
  // front panel
  input wire logic run_switch,
  input wire logic direction_switch,
  input wire logic dial_up,
  input wire logic dial_down,
  input wire logic dial_push,
  // motor drive and display
  output logic motor_run,
  output logic motor_reverse,
  output logic motor_instant_stop,
  output logic [SPW-1:0] motor_speed,
  output logic reject_shown,
  output logic edit_blink
);
  // ----------------------------------------
  // input conditioning
  // ----------------------------------------
  mrd_sw_if sw ();
  assign sw.raw = {dial_push, dial_down, dial_up, direction_switch, run_switch, ext_in};
  mrd_debounce #(.DEB_CYC(DEB_CYC)) u_deb (.pclk(pclk), .presetn(presetn), .sw(sw));

  logic [4:0] in_c;
  logic run_sw, dir_sw, up_c, dn_c, push_c;
  assign in_c = sw.clean[4:0];
  assign run_sw = sw.clean[5];
  assign dir_sw = sw.clean[6];
  assign up_c = sw.clean[7];
  assign dn_c = sw.clean[8];
  assign push_c = sw.clean[9];

  function automatic logic [SPW-1:0] clamp(input logic [SPW-1:0] v, input logic [SPW-1:0] lo,
                                           input logic [SPW-1:0] hi);
    logic [SPW-1:0] r;
    r = v;
    if (r > hi) r = hi;
    if (r < lo) r = lo;
    return r;
  endfunction : clamp

  function automatic logic func_hit(input logic [14:0] map, input logic [4:0] ins, input logic [2:0] fn);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (map[3*i +: 3] == fn && ins[i]) h = 1'b1;
    end
    return h;
  endfunction : func_hit

  // ----------------------------------------
  // configuration and operating data
  // ----------------------------------------
  logic [1:0] ext_q, ext_d;
  logic lock_q, lock_d;
  logic [2:0] disp_q, disp_d;
  logic [14:0] inmap_q, inmap_d;
  logic [3:0] outmap_q, outmap_d;
  logic [SPW-1:0] upper_q, upper_d, lower_q, lower_d;
  logic [SPW-1:0] speed_q [4];
  logic [SPW-1:0] speed_d [4];
  logic [SPW-1:0] edit_q, edit_d;
  logic blink_q, blink_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic wr, setup;
  logic dial_turn, dial_commit, monitor_view, dial_allowed;
  logic up_q, dn_q, push_q, dir_sw_q;
  mrd_state_t st_q, st_d;
  logic [SPW-1:0] spd_q, spd_d;
  logic rev_q, rev_d, halt_q, halt_d;
  logic [31:0] rej_q, rej_d;
  logic reject_q, reject_d;
  logic [1:0] out_q, out_d;
  logic motor_run_q, motor_run_d;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready_q;
  assign dial_turn = (up_c && !up_q) || (dn_c && !dn_q);
  assign dial_commit = push_c && !push_q;
  assign monitor_view = disp_q == DISP_SPEED || disp_q == DISP_ALARM || disp_q == DISP_WARN;
  assign dial_allowed = !lock_q && !(ext_q == EXT_LOCKED && monitor_view);

  always_comb begin
    ext_d = ext_q;
    lock_d = lock_q;
    disp_d = disp_q;
    inmap_d = inmap_q;
    outmap_d = outmap_q;
    upper_d = upper_q;
    lower_d = lower_q;
    edit_d = edit_q;
    blink_d = blink_q;
    for (int i = 0; i < 4; i++) speed_d[i] = speed_q[i];
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL: begin
          ext_d = pwdata[CTRL_EXT_LSB +: 2];
          lock_d = pwdata[CTRL_LOCK_BIT];
          disp_d = pwdata[CTRL_DISP_LSB +: 3];
        end
        ADDR_INMAP: inmap_d = pwdata[14:0];
        ADDR_OUTMAP: outmap_d = pwdata[3:0];
        ADDR_LIMIT: begin
          upper_d = pwdata[SPW-1:0];
          lower_d = pwdata[LIMIT_LOWER_LSB +: SPW];
        end
        ADDR_CMD: begin
          if (pwdata[CMD_INIT_DATA_BIT]) begin
            for (int i = 0; i < 4; i++) speed_d[i] = SPEED_RST;
            blink_d = 1'b0;
          end
          if (pwdata[CMD_INIT_PARAM_BIT]) begin
            ext_d = EXT_RST;
            lock_d = 1'b0;
            inmap_d = INMAP_RST;
            outmap_d = OUTMAP_RST;
            upper_d = UPPER_RST;
            lower_d = LOWER_RST;
          end
        end
        default: begin
          if (paddr[7:4] == ADDR_SPEED0[7:4] && paddr[1:0] == 2'h0) begin
            speed_d[paddr[3:2]] = pwdata[SPW-1:0];
          end
        end
      endcase
    end
    if (dial_allowed && (disp_q == DISP_SPEED || disp_q == DISP_DATA)) begin
      if (dial_turn) begin
        edit_d = blink_q ? edit_q : speed_q[0];
        edit_d = up_c && !up_q ? edit_d + 13'h1 : edit_d - 13'h1;
        edit_d = clamp(edit_d, lower_q, upper_q);
        blink_d = 1'b1;
      end else if (dial_commit && blink_q) begin
        speed_d[0] = edit_q;
        blink_d = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= EXT_RST;
      lock_q <= 1'b0;
      disp_q <= DISP_SPEED;
      inmap_q <= INMAP_RST;
      outmap_q <= OUTMAP_RST;
      upper_q <= UPPER_RST;
      lower_q <= LOWER_RST;
      edit_q <= SPEED_RST;
      blink_q <= 1'b0;
      for (int i = 0; i < 4; i++) speed_q[i] <= SPEED_RST;
    end else begin
      ext_q <= ext_d;
      lock_q <= lock_d;
      disp_q <= disp_d;
      inmap_q <= inmap_d;
      outmap_q <= outmap_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      edit_q <= edit_d;
      blink_q <= blink_d;
      for (int i = 0; i < 4; i++) speed_q[i] <= speed_d[i];
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    pready_d = setup;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d = 32'h0;
      unique case (paddr)
        ADDR_CTRL: begin
          prdata_d[CTRL_EXT_LSB +: 2] = ext_q;
          prdata_d[CTRL_LOCK_BIT] = lock_q;
          prdata_d[CTRL_DISP_LSB +: 3] = disp_q;
        end
        ADDR_INMAP: prdata_d[14:0] = inmap_q;
        ADDR_OUTMAP: prdata_d[3:0] = outmap_q;
        ADDR_LIMIT: begin
          prdata_d[SPW-1:0] = upper_q;
          prdata_d[LIMIT_LOWER_LSB +: SPW] = lower_q;
        end
        ADDR_STATUS: begin
          prdata_d[SPW-1:0] = spd_q;
          prdata_d[STAT_DIR_BIT] = rev_q;
          prdata_d[STAT_REJECT_BIT] = reject_q;
          prdata_d[STAT_STATE_LSB +: 5] = st_q;
        end
        ADDR_EDIT: begin
          prdata_d[SPW-1:0] = edit_q;
          prdata_d[EDIT_BLINK_BIT] = blink_q;
        end
        ADDR_CMD: prdata_d = 32'h0;
        default: begin
          if (paddr[7:4] == ADDR_SPEED0[7:4] && paddr[1:0] == 2'h0) begin
            prdata_d[SPW-1:0] = speed_q[paddr[3:2]];
          end else begin
            pslverr_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // run decision
  // ----------------------------------------
  logic fwd_in, rev_in, ext_any, ext_both, want, instant, dir_sel;
  logic [1:0] sel;
  logic [SPW-1:0] target;
  logic [9:0] tick_q, tick_d;
  logic step;

  assign fwd_in = func_hit(inmap_q, in_c, FN_FWD);
  assign rev_in = func_hit(inmap_q, in_c, FN_REV);
  assign sel = {func_hit(inmap_q, in_c, FN_SEL1), func_hit(inmap_q, in_c, FN_SEL0)};
  assign ext_any = fwd_in ^ rev_in;
  assign ext_both = fwd_in && rev_in;
  assign step = tick_q == 10'(RAMP_CYCLES - 1);

  always_comb begin
    want = run_sw;
    instant = 1'b0;
    dir_sel = dir_sw;
    target = clamp(speed_q[0], lower_q, upper_q);
    unique case (ext_q)
      EXT_ON: begin
        want = run_sw && ext_any;
        instant = ext_both;
        target = clamp(speed_q[sel], lower_q, upper_q);
      end
      EXT_LOCKED: begin
        want = ext_any;
        instant = ext_both;
        dir_sel = 1'b0;
        target = clamp(speed_q[sel], lower_q, upper_q);
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // motor sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    spd_d = spd_q;
    rev_d = rev_q;
    halt_d = 1'b0;
    tick_d = step ? 10'h0 : tick_q + 10'h1;
    unique case (st_q)
      ST_IDLE: begin
        spd_d = '0;
        rev_d = dir_sel;
        if (want && !instant) st_d = ST_RUN;
      end
      ST_RUN: begin
        if (step && spd_q < target) spd_d = spd_q + 13'h1;
        if (step && spd_q > target) spd_d = spd_q - 13'h1;
        if (instant) st_d = ST_HALT;
        else if (!want) st_d = ST_DECEL;
        else if (dir_sel != rev_q) st_d = ST_TURN;
      end
      ST_DECEL, ST_TURN: begin
        if (step && spd_q != '0) spd_d = spd_q - 13'h1;
        if (instant) st_d = ST_HALT;
        else if (st_q == ST_DECEL && want && dir_sel == rev_q) st_d = ST_RUN;
        else if (spd_q == '0) begin
          rev_d = dir_sel;
          st_d = want ? ST_RUN : ST_IDLE;
        end
      end
      ST_HALT: begin
        spd_d = '0;
        halt_d = 1'b1;
        if (!instant) st_d = ST_IDLE;
      end
    endcase
    if (st_d == ST_HALT) begin
      spd_d = '0;
      halt_d = 1'b1;
    end
    motor_run_d = st_d != ST_IDLE && st_d != ST_HALT;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      spd_q <= '0;
      rev_q <= 1'b0;
      halt_q <= 1'b0;
      tick_q <= 10'h0;
      motor_run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      spd_q <= spd_d;
      rev_q <= rev_d;
      halt_q <= halt_d;
      tick_q <= tick_d;
      motor_run_q <= motor_run_d;
    end
  end

  // ----------------------------------------
  // rejection display and mapped outputs
  // ----------------------------------------
  always_comb begin
    rej_d = rej_q == 32'h0 ? 32'h0 : rej_q - 32'h1;
    if (ext_q == EXT_LOCKED) begin
      if (dir_sw != dir_sw_q || (dial_turn && monitor_view && !lock_q)) begin
        rej_d = 32'(REJ_CYC);
      end
    end else begin
      rej_d = 32'h0;
    end
    reject_d = (ext_q == EXT_LOCKED && run_sw) || rej_d != 32'h0;
    for (int i = 0; i < 2; i++) begin
      unique case (outmap_q[2*i +: 2])
        OFN_RUN: out_d[i] = motor_run_q;
        OFN_REJECT: out_d[i] = reject_q;
        OFN_REVDIR: out_d[i] = rev_q;
        default: out_d[i] = halt_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rej_q <= 32'h0;
      reject_q <= 1'b0;
      out_q <= 2'h0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      push_q <= 1'b0;
      dir_sw_q <= 1'b0;
    end else begin
      rej_q <= rej_d;
      reject_q <= reject_d;
      out_q <= out_d;
      up_q <= up_c;
      dn_q <= dn_c;
      push_q <= push_c;
      dir_sw_q <= dir_sw;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ext_out = out_q;
  assign motor_run = motor_run_q;
  assign motor_reverse = rev_q;
  assign motor_instant_stop = halt_q;
  assign motor_speed = spd_q;
  assign reject_shown = reject_q;
  assign edit_blink = blink_q;
endmodule : mrd_motor_ctrl

// [tb/mrd_motor_ctrl_props.sv]
`timescale 1ns/1ps
module mrd_motor_ctrl_props
  import mrd_pkg::*;
#(
  parameter int DEB_CYC = DEB_CYCLES,
  parameter int REJ_CYC = REJECT_CYCLES
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // motor drive
  input wire logic motor_run,
  input wire logic motor_reverse,
  input wire logic motor_instant_stop,
  input wire logic [SPW-1:0] motor_speed
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no answer in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // ----------------------------------------
  // motion
  // ----------------------------------------
  a_halt_no_motion: assert property (motor_instant_stop |-> !motor_run && motor_speed == '0)
    else $error("instant stop with motion");
  a_idle_no_speed: assert property (!motor_run |-> motor_speed == '0)
    else $error("speed while stopped");
  a_ramp_step: assert property (!motor_instant_stop && $changed(motor_speed) |->
    motor_speed == $past(motor_speed) + 13'h1 || $past(motor_speed) == motor_speed + 13'h1)
    else $error("speed jump without ramp");
  a_turn_at_rest: assert property ($changed(motor_reverse) |-> motor_speed == '0)
    else $error("direction flip while turning");
endmodule : mrd_motor_ctrl_props

bind mrd_motor_ctrl mrd_motor_ctrl_props #(.DEB_CYC(DEB_CYC), .REJ_CYC(REJ_CYC)) i_mrd_motor_ctrl_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_run(motor_run),
  .motor_reverse(motor_reverse), .motor_instant_stop(motor_instant_stop), .motor_speed(motor_speed)
);

// [tb/mrd_plc_model.sv]
`timescale 1ns/1ps
module mrd_plc_model (
  // clock
  input wire logic pclk,
  // commands from the bench
  input wire logic fwd_cmd,
  input wire logic rev_cmd,
  // run inputs toward the device
  output logic [1:0] run_out
);
  // ----------------------------------------
  // run input drive, both only when commanded
  // ----------------------------------------
  always @(posedge pclk) begin
    run_out <= {rev_cmd, fwd_cmd};
  end
endmodule : mrd_plc_model

// [tb/tb_mrd_motor_ctrl.sv]
`timescale 1ns/1ps
module tb_mrd_motor_ctrl;
  import mrd_pkg::*;
  localparam int LIM = 6000;
  localparam int REJ = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] ext_out, plc_run, sel;
  logic [2:0] dial;
  logic [SPW-1:0] motor_speed, rnd;
  logic forward_run_input, reverse_run_input, run_switch, direction_switch;
  logic motor_run, motor_reverse, motor_instant_stop, reject_shown, edit_blink;
  int miscompares, total_checks, seed, k;

  mrd_plc_model i_mrd_plc_model (.pclk(pclk), .fwd_cmd(forward_run_input), .rev_cmd(reverse_run_input), .run_out(plc_run));
  mrd_motor_ctrl #(.DEB_CYC(4), .REJ_CYC(REJ)) i_mrd_motor_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_in({1'b0, sel, plc_run}), .ext_out(ext_out), .run_switch(run_switch),
    .direction_switch(direction_switch), .dial_up(dial[0]), .dial_down(dial[1]), .dial_push(dial[2]),
    .motor_run(motor_run), .motor_reverse(motor_reverse), .motor_instant_stop(motor_instant_stop),
    .motor_speed(motor_speed), .reject_shown(reject_shown), .edit_blink(edit_blink)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks and expectations
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic apb(input int wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= 1'(wr);
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      miscompares++;
      end_of_test();
    end
  endtask : apb

  task automatic wait_on(input int s, input logic v);
    int n;
    n = 0;
    while (n < LIM && (s == 0 ? motor_run : s == 1 ? motor_reverse : reject_shown) !== v) begin
      @(posedge pclk);
      n++;
    end
    if (n >= LIM) begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_on

  task automatic pulse(input int b);
    dial[b] <= 1'b1;
    repeat (20) @(posedge pclk);
    dial[b] <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask : pulse

  function automatic logic [31:0] exp_limit(input logic [SPW-1:0] up, input logic [SPW-1:0] lo);
    return {3'h0, lo, 3'h0, up};
  endfunction : exp_limit

  function automatic logic exp_dir(input logic [1:0] mode, input logic sw);
    return (mode == EXT_LOCKED) ? 1'b0 : sw;
  endfunction : exp_dir

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 75;
    {presetn, psel, penable, pwrite, forward_run_input, reverse_run_input, run_switch, direction_switch} = '0;
    paddr = '0;
    pwdata = '0;
    dial = '0;
    sel = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, refused address, random slots
    apb(0, ADDR_CTRL, 0);
    chk(rd, 0);
    apb(0, ADDR_LIMIT, 0);
    chk(rd, exp_limit(UPPER_RST, LOWER_RST));
    apb(0, ADDR_INMAP, 0);
    chk(rd, {17'h0, INMAP_RST});
    apb(0, ADDR_OUTMAP, 0);
    chk(rd, {28'h0, OUTMAP_RST});
    apb(0, 8'h04, 0);
    chk({last_err, rd[30:0]}, {1'b1, 31'h0});
    for (int i = 1; i < 4; i++) begin
      rnd = 13'($random(seed));
      sel <= 2'($random(seed));
      apb(1, ADDR_SPEED0 + 8'(4 * i), {19'h0, rnd});
      apb(0, ADDR_SPEED0 + 8'(4 * i), 0);
      chk(rd, {19'h0, rnd});
    end
    // panel mode ignores the controller
    forward_run_input <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(motor_run, 0);
    forward_run_input <= 1'b0;
    apb(1, ADDR_CTRL, {30'h0, EXT_ON});
    // run, turn while running, standby stop
    run_switch <= 1'b1;
    forward_run_input <= 1'b1;
    wait_on(0, 1);
    chk(motor_reverse, exp_dir(EXT_ON, 1'b0));
    repeat (2100) @(posedge pclk);
    chk(motor_speed > 13'h0, 1);
    direction_switch <= 1'b1;
    wait_on(1, exp_dir(EXT_ON, 1'b1));
    chk(motor_run, 1);
    repeat (2100) @(posedge pclk);
    run_switch <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(0, ADDR_STATUS, 0);
    chk(rd[22:18], ST_DECEL);
    wait_on(0, 0);
    // release gives a ramp, both inputs give instant stop
    run_switch <= 1'b1;
    wait_on(0, 1);
    repeat (2100) @(posedge pclk);
    forward_run_input <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(motor_run, 1);
    wait_on(0, 0);
    forward_run_input <= 1'b1;
    wait_on(0, 1);
    repeat (1100) @(posedge pclk);
    reverse_run_input <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({motor_instant_stop, motor_speed}, {1'b1, 13'h0});
    {forward_run_input, reverse_run_input} <= 2'b00;
    // dial edit commits on push only
    pulse(0);
    pulse(0);
    pulse(1);
    chk(edit_blink, 1);
    apb(0, ADDR_SPEED0, 0);
    chk(rd, {19'h0, SPEED_RST});
    pulse(2);
    chk(edit_blink, 0);
    apb(0, ADDR_SPEED0, 0);
    chk(rd, {19'h0, SPEED_RST + 13'h1});
    run_switch <= 1'b0;
    apb(1, ADDR_CTRL, 32'h4 | EXT_ON);
    pulse(0);
    chk(edit_blink, 0);
    // factory restore commands
    apb(1, ADDR_CMD, 32'h1);
    apb(0, ADDR_SPEED0, 0);
    chk(rd, {19'h0, SPEED_RST});
    apb(1, ADDR_LIMIT, exp_limit(13'h100, 13'h40));
    apb(1, ADDR_CMD, 32'h2);
    apb(0, ADDR_LIMIT, 0);
    chk(rd, exp_limit(UPPER_RST, LOWER_RST));
    // locked panel
    apb(1, ADDR_CTRL, {30'h0, EXT_LOCKED});
    run_switch <= 1'b1;
    forward_run_input <= 1'b1;
    wait_on(0, 1);
    chk(motor_reverse, exp_dir(EXT_LOCKED, direction_switch));
    repeat (2 * REJ) @(posedge pclk);
    chk(reject_shown, 1);
    chk(ext_out, 2'h3);
    run_switch <= 1'b0;
    forward_run_input <= 1'b0;
    wait_on(0, 0);
    wait_on(2, 0);
    direction_switch <= 1'b0;
    wait_on(2, 1);
    chk(motor_reverse, 0);
    k = 0;
    while (reject_shown === 1'b1 && k < LIM) begin
      @(posedge pclk);
      k++;
    end
    chk(k >= REJ - 3 && k <= REJ + 3, 1);
    pulse(0);
    chk({reject_shown, edit_blink}, 2'b10);
    wait_on(2, 0);
    apb(1, ADDR_CTRL, {25'h0, DISP_DATA, 2'h0, EXT_LOCKED});
    pulse(0);
    chk({reject_shown, edit_blink}, 2'b01);
    end_of_test();
  end
endmodule : tb_mrd_motor_ctrl
